// *** src/fci_top.sv ***
`include "fci_consts.svh"
`default_nettype none
// Contract
// - Verify finding both blocks blank sets flag
// - Complete with flag clear means not blank
// - Command bit 7 ignores writes, reads zero
// - Unknown command code sets access error
// - Decode verify, program, page and mass erase
// - Factory registers give transfer error outside test
// - Aligned reads finish in one cycle
// - Misaligned access gives transfer error
// - Sense amplifiers switch off after 50 ns; code drops them after 6 cycles, 48 ns at an 8 ns clock
// - Only aligned word writes to the array
// - Array write only latches address and data
// - Two-entry command queue
// - Keep pumps on for same-row programs
// - Timebase from programmable counter on module clock
// - Buffer-empty and complete flags request interrupts
// - Timebase is sys/(1+7p)/(ratio+1)
// - Array writes obey the key access bit
// - Ratio write sets flag; unlocks commands
// - Write one to buffer-empty launches command
// - Command register locked while buffer full
module fci_top #(
  parameter logic [15:0] PgmTicks = 16'h0010, // Program length in timebase ticks
  parameter logic [15:0] PageTicks = 16'h0020, // Page erase length
  parameter logic [15:0] MassTicks = 16'h0040, // Mass erase length
  parameter logic [15:0] VerifyTicks = 16'h0008 // Erase verify length
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic testMode,
  input wire fci_pkg::fci_bus_req_t busReq,
  output var fci_pkg::fci_bus_rsp_t busRsp,
  input wire logic [31:0] arrayRdData,
  input wire logic arrayBlank,
  output var logic senseAmpEn,
  output var fci_pkg::fci_array_op_t arrayOp,
  output var logic irqReq
);
  import fci_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address falls in [off, off + span)
  function automatic logic regHit(input logic [31:0] a, input logic [31:0] off, input logic [31:0] span);
    regHit = (a >= off) && (a < off + span);
  endfunction

  // Command code is one of the four user commands
  function automatic logic cmdValid(input logic [6:0] c);
    cmdValid = (c == `FCI_CMD_VERIFY) || (c == `FCI_CMD_PROGRAM) ||
               (c == `FCI_CMD_PAGE_ERS) || (c == `FCI_CMD_MASS_ERS);
  endfunction

  // Length of each command in timebase ticks
  function automatic logic [15:0] opTicks(input logic [6:0] c);
    case (c)
      `FCI_CMD_PROGRAM: opTicks = PgmTicks;
      `FCI_CMD_PAGE_ERS: opTicks = PageTicks;
      `FCI_CMD_MASS_ERS: opTicks = MassTicks;
      default: opTicks = VerifyTicks;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] mcr_r; // Interrupt enables and key access
  logic [7:0] clkd_r; // Ratio-written, prescale and ratio
  logic [7:0] cmd_r; // Command register, bit 7 always zero
  logic buffer_empty_flag_r; // Buffer empty
  logic command_complete_flag_r; // All commands complete
  logic access_error_flag_r; // Access error, sticky
  logic blank_r; // Erase verified, sticky
  fci_seq_e_t seq_r; // Command write sequence
  logic [31:0] wordAddr_r; // Latched array write address
  logic [31:0] wordData_r; // Latched array write data
  fci_entry_t pend_r; // Queue stage waiting to run
  fci_entry_t exec_r; // Queue stage running
  logic [15:0] ticks_r; // Timebase ticks spent on the running command
  logic [2:0] sense_amp_timeout_r; // Sense amplifier on-time left
  logic tbTick; // Timebase tick

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire logic [31:0] addr = busReq.addr;
  wire logic inFlash = addr < `FCI_FLASH_SIZE;
  wire logic inRegs = regHit(addr, `FCI_REG_BASE, `FCI_REG_SPAN);
  wire logic hitMcr = regHit(addr, `FCI_OFF_MCR, `FCI_SPAN_BYTE);
  wire logic hitClkd = regHit(addr, `FCI_OFF_CLKD, `FCI_SPAN_BYTE);
  wire logic hitUstat = regHit(addr, `FCI_OFF_USTAT, `FCI_SPAN_BYTE);
  wire logic hitCmd = regHit(addr, `FCI_OFF_CMD, `FCI_SPAN_BYTE);
  wire logic hitFact = regHit(addr, `FCI_OFF_FCTL, `FCI_SPAN_HALF) |
                       regHit(addr, `FCI_OFF_FADR, `FCI_SPAN_HALF) |
                       regHit(addr, `FCI_OFF_FDATA, `FCI_SPAN_WORD);
  wire logic hitKnown = hitMcr | hitClkd | hitUstat | hitCmd;

  // Error causes, any of which ends the cycle with a transfer error
  wire logic misaligned = ((busReq.size == SZ_HALF) & addr[0]) |
                          ((busReq.size == SZ_WORD) & (addr[1:0] != 2'h0)) |
                          (busReq.size == SZ_RSVD);
  wire logic narrowWr = busReq.write & inFlash & (busReq.size != SZ_WORD);
  wire logic factBlock = hitFact & ~testMode;
  wire logic unmapped = ~inFlash & ~(inRegs & (hitKnown | hitFact));
  wire logic errNow = misaligned | narrowWr | factBlock | unmapped;

  // Accepted accesses
  wire logic take = busReq.req & clkEn;
  wire logic wrOk = take & busReq.write & ~errNow;
  wire logic rdOk = take & ~busReq.write & ~errNow;
  wire logic key_access_bit = mcr_r[`FCI_MCR_KEY_ACCESS_BIT];
  wire logic wrMcr = wrOk & hitMcr;
  wire logic wrClkd = wrOk & hitClkd;
  wire logic wrUstat = wrOk & hitUstat;
  wire logic wrCmd = wrOk & hitCmd;
  // With key access set, array writes serve the key path and skip the sequence
  wire logic wrArray = wrOk & inFlash & ~key_access_bit;
  wire logic ratioWritten = clkd_r[`FCI_CLKD_RATIO_WRITTEN_FLAG];
  wire logic [7:0] wd8 = busReq.wdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence events

  // Array write out of order, before the ratio is set, or with buffer full
  wire logic arrErr = wrArray & (~ratioWritten | ~buffer_empty_flag_r | (seq_r != SEQ_IDLE));
  // Command written out of order or with an unknown code; blocked when full
  wire logic cmdTake = wrCmd & buffer_empty_flag_r;
  wire logic cmdErr = cmdTake & ((seq_r != SEQ_WORD) | ~cmdValid(wd8[6:0]));
  // Writing zero to buffer-empty mid-sequence aborts it
  wire logic abortErr = wrUstat & ~wd8[`FCI_ST_BUFFER_EMPTY_FLAG] & (seq_r != SEQ_IDLE);
  // Other register writes between the sequence steps are illegal
  wire logic otherErr = (wrMcr | wrClkd) & (seq_r != SEQ_IDLE);
  wire logic setErr = arrErr | cmdErr | abortErr | otherErr;
  wire logic launch = wrUstat & wd8[`FCI_ST_BUFFER_EMPTY_FLAG] & (seq_r == SEQ_CMD) & buffer_empty_flag_r & ~access_error_flag_r;

  // Queue movement
  wire logic execDone = exec_r.valid & tbTick & (ticks_r == opTicks(exec_r.cmd) - 16'h0001);
  wire logic advance = pend_r.valid & (~exec_r.valid | execDone);
  wire logic execValidNxt = advance | (exec_r.valid & ~execDone);
  wire logic pendValidNxt = launch | (pend_r.valid & ~advance);
  // Same-row program follows a program: pumps stay up
  wire logic keepRow = (exec_r.cmd == `FCI_CMD_PROGRAM) & (pend_r.cmd == `FCI_CMD_PROGRAM) &
                       (exec_r.addr[31:`FCI_ROW_LSB] == pend_r.addr[31:`FCI_ROW_LSB]) &
                       exec_r.valid;
  wire logic blankSet = execDone & (exec_r.cmd == `FCI_CMD_VERIFY) & arrayBlank;

  // Register read data, narrow registers in the low byte
  wire logic [7:0] ustatVal = {buffer_empty_flag_r, command_complete_flag_r, 1'b0, access_error_flag_r, 1'b0, blank_r, 2'h0};
  wire logic [31:0] rdMux = inFlash ? arrayRdData :
                            hitMcr ? {24'h00_0000, mcr_r} :
                            hitClkd ? {24'h00_0000, clkd_r} :
                            hitUstat ? {24'h00_0000, ustatVal} :
                            hitCmd ? {24'h00_0000, cmd_r} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase divider, running only while a command executes
  fci_timebase u_timebase (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .run(exec_r.valid),
    .prescaleByEight(clkd_r[`FCI_CLKD_PRDIV]),
    .ratio(clkd_r[`FCI_CLKD_RATIO_HI:0]),
    .tick(tbTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: every access answers on the following edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busRsp <= '0;
    end else if (clkEn) begin
      busRsp.done <= busReq.req;
      busRsp.err <= busReq.req & errNow;
      busRsp.rdata <= rdOk ? rdMux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense amplifiers: an array read retriggers the on-time, then they drop to save power
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      senseAmpEn <= 1'b0;
      sense_amp_timeout_r <= 3'h0;
    end else if (clkEn) begin
      if (rdOk & inFlash) begin
        senseAmpEn <= 1'b1;
        sense_amp_timeout_r <= 3'(`FCI_SENSE_AMP_TIMEOUT_CYC - 1);
      end else if (sense_amp_timeout_r != 3'h0) begin
        sense_amp_timeout_r <= sense_amp_timeout_r - 3'h1;
      end else begin
        senseAmpEn <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; ratio-written flag sets on any ratio write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mcr_r <= `FCI_RST_MCR;
      clkd_r <= `FCI_RST_CLKD;
    end else if (clkEn) begin
      if (wrMcr) begin
        mcr_r <= wd8;
      end
      if (wrClkd) begin
        clkd_r <= {1'b1, wd8[6:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command write sequence: latch word, take command, wait for launch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      seq_r <= SEQ_IDLE;
      cmd_r <= `FCI_RST_CMD;
      wordAddr_r <= 32'h0000_0000;
      wordData_r <= 32'h0000_0000;
    end else if (clkEn) begin
      if (cmdTake) begin
        cmd_r <= {1'b0, wd8[6:0]};
      end
      if (wrArray & ~arrErr) begin
        wordAddr_r <= addr;
        wordData_r <= busReq.wdata;
      end
      // Any access error self-aborts the sequence
      case (seq_r)
        SEQ_IDLE: begin
          if (wrArray & ~arrErr) begin
            seq_r <= SEQ_WORD;
          end
        end
        SEQ_WORD: begin
          if (setErr) begin
            seq_r <= SEQ_IDLE;
          end else if (cmdTake) begin
            seq_r <= SEQ_CMD;
          end
        end
        SEQ_CMD: begin
          if (setErr | launch) begin
            seq_r <= SEQ_IDLE;
          end
        end
        default: begin
          seq_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set beats a same-cycle software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      buffer_empty_flag_r <= 1'b1;
      command_complete_flag_r <= 1'b1;
      access_error_flag_r <= 1'b0;
      blank_r <= 1'b0;
    end else if (clkEn) begin
      access_error_flag_r <= setErr | (access_error_flag_r & ~(wrUstat & wd8[`FCI_ST_ACCESS_ERROR_FLAG]));
      blank_r <= blankSet | (blank_r & ~(wrUstat & wd8[`FCI_ST_BLANK]));
      // Buffer empty falls at launch, rises when the entry moves to execution
      if (launch) begin
        buffer_empty_flag_r <= 1'b0;
      end else if (advance) begin
        buffer_empty_flag_r <= 1'b1;
      end
      command_complete_flag_r <= ~(pendValidNxt | execValidNxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage queue and execution timer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend_r <= '0;
      exec_r <= '0;
      ticks_r <= 16'h0000;
    end else if (clkEn) begin
      if (launch) begin
        pend_r <= '{valid: 1'b1, cmd: cmd_r[6:0], addr: wordAddr_r, data: wordData_r};
      end else if (advance) begin
        pend_r.valid <= 1'b0;
      end
      if (advance) begin
        exec_r <= pend_r;
        ticks_r <= 16'h0000;
      end else if (execDone) begin
        exec_r.valid <= 1'b0;
      end else if (exec_r.valid & tbTick) begin
        ticks_r <= ticks_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array command port and interrupt request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arrayOp <= '0;
      irqReq <= 1'b0;
    end else if (clkEn) begin
      arrayOp.start <= advance;
      arrayOp.pumpKeep <= advance & keepRow;
      arrayOp.pumpOn <= execValidNxt & ~(execDone & ~keepRow);
      if (advance) begin
        arrayOp.cmd <= pend_r.cmd;
        arrayOp.addr <= pend_r.addr;
        arrayOp.data <= pend_r.data;
      end
      irqReq <= (buffer_empty_flag_r & mcr_r[`FCI_MCR_CBEIE]) | (command_complete_flag_r & mcr_r[`FCI_MCR_CCIE]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_read_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdOk |=> (busRsp.done && !busRsp.err)) else $error("aligned read not answered next cycle");
  chk_misalign_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && misaligned) |=> (busRsp.done && busRsp.err)) else $error("misaligned access not refused");
  chk_narrow_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && narrowWr) |=> busRsp.err && $stable(seq_r)) else $error("narrow array write accepted");
  chk_factory_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && hitFact && !testMode) |=> busRsp.err) else $error("factory register reached outside test");
  chk_cmd_bit_seven: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rdOk && hitCmd) |=> (busRsp.rdata[7] == 1'b0)) else $error("command bit 7 read as one");
  chk_cmd_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrCmd && !buffer_empty_flag_r) |=> $stable(cmd_r)) else $error("command written while buffer full");
  chk_bad_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmdTake && !cmdValid(wd8[6:0])) |=> access_error_flag_r) else $error("unknown command left no access error");
  chk_ratio_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrClkd && !wrArray) |=> (ratioWritten && !arrErr)) else $error("ratio write did not set flag");
  chk_early_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrArray && !ratioWritten) |=> (access_error_flag_r && seq_r == SEQ_IDLE)) else $error("array write before ratio");
  chk_sense_amp_timeout_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rdOk && inFlash) ##1 (clkEn && !rdOk)[*7] |=> !senseAmpEn) else $error("sense amps left on");
  chk_launch_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    launch |=> (!buffer_empty_flag_r && !command_complete_flag_r && pend_r.valid)) else $error("launch did not queue command");
  chk_done_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && execDone && !pend_r.valid && !launch) |=> (command_complete_flag_r && !exec_r.valid)) else $error("no completion");
  chk_tb_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!exec_r.valid && clkEn) |=> !tbTick) else $error("timebase ticked with nothing running");

endmodule
`default_nettype wire

// *** src/fci_consts.svh ***
`ifndef FCI_CONSTS_SVH
`define FCI_CONSTS_SVH

// Address map: flash array space and register block
`define FCI_FLASH_SIZE 32'h0004_0000
`define FCI_REG_BASE 32'h00D0_0000
`define FCI_REG_SPAN 32'h0000_0030
`define FCI_OFF_MCR 32'h00D0_0000
`define FCI_OFF_CLKD 32'h00D0_0002
`define FCI_OFF_USTAT 32'h00D0_001C
`define FCI_OFF_CMD 32'h00D0_0020
`define FCI_OFF_FCTL 32'h00D0_0024
`define FCI_OFF_FADR 32'h00D0_0026
`define FCI_OFF_FDATA 32'h00D0_0028
`define FCI_SPAN_BYTE 32'h0000_0001
`define FCI_SPAN_HALF 32'h0000_0002
`define FCI_SPAN_WORD 32'h0000_0004

// Module config register fields
`define FCI_MCR_CBEIE 7
`define FCI_MCR_CCIE 6
`define FCI_MCR_KEY_ACCESS_BIT 5

// Timebase ratio register fields
`define FCI_CLKD_RATIO_WRITTEN_FLAG 7
`define FCI_CLKD_PRDIV 6
`define FCI_CLKD_RATIO_HI 5

// User status register fields
`define FCI_ST_BUFFER_EMPTY_FLAG 7
`define FCI_ST_COMMAND_COMPLETE_FLAG 6
`define FCI_ST_PROTECTION_VIOLATION_FLAG 5
`define FCI_ST_ACCESS_ERROR_FLAG 4
`define FCI_ST_BLANK 2

// Command register: bit 7 is reserved
`define FCI_CMD_RSVD 7

// Command codes
`define FCI_CMD_VERIFY 7'h05
`define FCI_CMD_PROGRAM 7'h20
`define FCI_CMD_PAGE_ERS 7'h40
`define FCI_CMD_MASS_ERS 7'h41

// Reset values
`define FCI_RST_MCR 8'h00
`define FCI_RST_CLKD 8'h00
`define FCI_RST_CMD 8'h00

// Lowest address bit that selects a program row
`define FCI_ROW_LSB 8

// Sense amplifier on-time: 50 ns at an 8 ns clock, rounded down
`define FCI_SENSE_AMP_TIMEOUT_NS 50
`define FCI_CLK_NS 8
`define FCI_SENSE_AMP_TIMEOUT_CYC (`FCI_SENSE_AMP_TIMEOUT_NS / `FCI_CLK_NS)

`endif

// *** src/fci_pkg.sv ***
`default_nettype none
package fci_pkg;

  // Access width on the local memory bus
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_RSVD = 2'h3
  } fci_size_e_t;

  // Command sequence state, Gray along idle -> word -> command
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_WORD = 2'h1,
    SEQ_CMD = 2'h3
  } fci_seq_e_t;

  // Bus request from the core
  typedef struct packed {
    logic req;
    logic write;
    fci_size_e_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fci_bus_req_t;

  // Bus answer, one cycle after the request
  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } fci_bus_rsp_t;

  // One queued command with its latched address and data
  typedef struct packed {
    logic valid;
    logic [6:0] cmd;
    logic [31:0] addr;
    logic [31:0] data;
  } fci_entry_t;

  // Command handed to the flash array
  typedef struct packed {
    logic start;
    logic pumpKeep;
    logic pumpOn;
    logic [6:0] cmd;
    logic [31:0] addr;
    logic [31:0] data;
  } fci_array_op_t;

endpackage
`default_nettype wire

// *** src/fci_timebase.sv ***
`include "fci_consts.svh"
`default_nettype none
module fci_timebase (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic run,
  input wire logic prescaleByEight,
  input wire logic [5:0] ratio,
  output var logic tick
);

  logic [2:0] pre_r; // Divide-by-eight prescaler
  logic [5:0] div_r; // Ratio counter
  logic preTick; // Prescaled clock enable

  // Prescaler passes every cycle unless divide-by-eight is chosen
  assign preTick = ~prescaleByEight | (pre_r == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Counters are held clear while no command runs, which saves toggling
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pre_r <= 3'h0;
      div_r <= 6'h00;
      tick <= 1'b0;
    end else if (clkEn) begin
      if (!run) begin
        pre_r <= 3'h0;
        div_r <= 6'h00;
        tick <= 1'b0;
      end else begin
        // Rate is sys / (1 + 7*p) / (ratio + 1)
        pre_r <= prescaleByEight ? pre_r + 3'h1 : 3'h0;
        tick <= 1'b0;
        if (preTick) begin
          if (div_r == ratio) begin
            div_r <= 6'h00;
            tick <= 1'b1;
          end else begin
            div_r <= div_r + 6'h01;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/fci_flash_model.sv ***
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Flash array stand-in: word contents follow the address, blank answer from the bench
module fci_flash_model (
  input wire logic [31:0] addr,
  input wire logic blankSet,
  output logic [31:0] rdData,
  output logic blank
);
  timeunit 1ns;
  timeprecision 1ps;
  // Upper half inverts the lower half, so swapped or stuck lanes show up
  assign rdData = {~addr[15:0], addr[15:0]};
  // Blank answer as the scenario demands
  assign blank = blankSet;
endmodule
`default_nettype wire

// *** tb/flash_command_interface_tb_top.sv ***
`include "fci_consts.svh"
`default_nettype none
module flash_command_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fci_pkg::*;
  localparam logic [31:0] MC = `FCI_OFF_MCR;
  localparam logic [31:0] CK = `FCI_OFF_CLKD;
  localparam logic [31:0] ST = `FCI_OFF_USTAT;
  localparam logic [31:0] CM = `FCI_OFF_CMD;
  localparam logic [31:0] RA = 32'h400; // Program row base
  // Bench inputs start known at time zero
  logic sys_clk = 0;
  logic rst_n = 0;
  logic testMode = 0;
  logic blankSet = 0;
  fci_bus_req_t busReq = '0;
  fci_bus_rsp_t busRsp;
  fci_array_op_t arrayOp;
  logic senseAmpEn;
  logic irqReq;
  logic arrayBlank;
  logic [31:0] arrayRdData;
  logic [31:0] q; // Last read data
  int n_errors = 0;
  int total_checks = 0;
  //////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  fci_flash_model i_flash (.addr(busReq.addr), .blankSet(blankSet), .rdData(arrayRdData), .blank(arrayBlank));
  // Short tick counts keep each command near 1030 cycles at the slowest timebase
  fci_top #(.PgmTicks(16'h2), .PageTicks(16'h2), .MassTicks(16'h2), .VerifyTicks(16'h2)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .testMode(testMode), .busReq(busReq),
    .busRsp(busRsp), .arrayRdData(arrayRdData), .arrayBlank(arrayBlank), .senseAmpEn(senseAmpEn),
    .arrayOp(arrayOp), .irqReq(irqReq));
  //////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One access: request held one cycle, answer checked the cycle after
  task automatic acc(input logic w, input fci_size_e_t z, input logic [31:0] a, input logic [31:0] d,
    input logic e);
    @(posedge sys_clk); #1;
    busReq = {1'b1, w, z, a, d};
    @(posedge sys_clk); #1;
    busReq.req = 0;
    chk(busRsp.done, 1);
    chk(busRsp.err, e);
    q = busRsp.rdata;
  endtask
  // Word, command, launch
  task automatic seq(input logic [7:0] c, input logic [31:0] a, input logic [31:0] d);
    acc(1, SZ_WORD, a, d, 0);
    acc(1, SZ_BYTE, CM, c, 0);
    acc(1, SZ_BYTE, ST, 8'h80, 0);
  endtask
  // Bounded wait for the array hand-off, then compare what it carries
  task automatic took(input logic [6:0] c, input logic [31:0] a, input logic [31:0] d, input logic k);
    for (int i = 0; i < 2000 && arrayOp.start !== 1'b1; i++) begin
      @(posedge sys_clk); #1;
    end
    chk(arrayOp.start, 1);
    if (arrayOp.start !== 1'b1) print_verdict();
    chk(arrayOp.cmd, c);
    chk(arrayOp.addr, a);
    chk(arrayOp.data, d);
    chk(arrayOp.pumpKeep, k);
    chk(arrayOp.pumpOn, 1);
  endtask
  // Poll status until complete; q keeps the final status
  task automatic wait_done();
    for (int i = 0; i < 1500; i++) begin
      acc(0, SZ_BYTE, ST, 0, 0);
      if (q[6] === 1'b1) return;
    end
    n_errors++;
    print_verdict();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_access();
    acc(0, SZ_WORD, 32'h100, 0, 0);
    chk(q, 32'hFEFF0100);
    chk(senseAmpEn, 1);
    repeat (5) @(posedge sys_clk);
    #1;
    chk(senseAmpEn, 1);
    @(posedge sys_clk); #1;
    chk(senseAmpEn, 0);
    acc(0, SZ_BYTE, 32'h103, 0, 0);
    acc(0, SZ_HALF, 32'h101, 0, 1);
    acc(0, SZ_WORD, 32'h102, 0, 1);
    acc(1, SZ_BYTE, 32'h200, 0, 1);
    acc(1, SZ_HALF, 32'h200, 0, 1);
    acc(0, SZ_HALF, 32'hD00024, 0, 1);
    acc(1, SZ_WORD, 32'hD00028, 0, 1);
    acc(0, SZ_BYTE, 32'hD00010, 0, 1);
    testMode = 1;
    acc(0, SZ_HALF, 32'hD00026, 0, 0);
    chk(q, 32'h0);
    testMode = 0;
    // Array word write before the ratio is set must be flagged, refused ones must not
    acc(1, SZ_WORD, RA, 32'h1, 0);
    acc(0, SZ_BYTE, ST, 0, 0);
    chk(q, 8'hD0);
    acc(1, SZ_BYTE, ST, 8'h10, 0);
    $display("test access done");
  endtask
  task automatic t_setup();
    // Prescale on above 12.8 MHz; the ideal ratio 78 does not fit six bits,
    // so the top ratio 63 gives the slowest timebase this clock allows
    acc(1, SZ_BYTE, CK, 8'h7F, 0);
    acc(0, SZ_BYTE, CK, 0, 0);
    chk(q, 8'hFF);
    acc(1, SZ_BYTE, MC, 8'h80, 0);
    @(posedge sys_clk); #1;
    chk(irqReq, 1);
    acc(1, SZ_BYTE, MC, 8'h00, 0);
    @(posedge sys_clk); #1;
    chk(irqReq, 0);
    // Key access: the array write is not latched, so the command comes out of order
    acc(1, SZ_BYTE, MC, 8'h20, 0);
    acc(1, SZ_WORD, RA, 32'h5, 0);
    acc(1, SZ_BYTE, CM, 8'h05, 0);
    acc(0, SZ_BYTE, ST, 0, 0);
    chk(q, 8'hD0);
    acc(1, SZ_BYTE, ST, 8'h10, 0);
    acc(1, SZ_BYTE, MC, 8'h00, 0);
    $display("test setup done");
  endtask
  task automatic t_prog();
    acc(1, SZ_WORD, RA, 32'h12345678, 0);
    acc(1, SZ_BYTE, CM, 8'hA0, 0);
    acc(0, SZ_BYTE, CM, 0, 0);
    chk(q, 8'h20);
    acc(1, SZ_BYTE, ST, 8'h80, 0);
    took(7'h20, RA, 32'h12345678, 0);
    // Second program to the same row queues behind the first
    seq(8'h20, RA + 32'h4, 32'hCAFE0001);
    acc(1, SZ_BYTE, CM, 8'h40, 0);
    acc(0, SZ_BYTE, ST, 0, 0);
    chk(q, 8'h00);
    took(7'h20, RA + 32'h4, 32'hCAFE0001, 1);
    wait_done();
    chk(q, 8'hC0);
    chk(arrayOp.pumpOn, 0);
    $display("test program done");
  endtask
  task automatic t_cmds();
    logic [7:0] c[3] = '{8'h05, 8'h40, 8'h41};
    blankSet = 1;
    seq(8'h05, RA, 0);
    wait_done();
    chk(q, 8'hC4);
    acc(1, SZ_BYTE, ST, 8'h00, 0);
    acc(0, SZ_BYTE, ST, 0, 0);
    chk(q, 8'hC4);
    acc(1, SZ_BYTE, ST, 8'h04, 0);
    blankSet = 0;
    foreach (c[i]) begin
      seq(c[i], RA, 0);
      took(c[i][6:0], RA, 0, 0);
      wait_done();
      chk(q, 8'hC0);
    end
    acc(1, SZ_WORD, RA, 0, 0);
    acc(1, SZ_BYTE, CM, 8'h33, 0);
    acc(0, SZ_BYTE, ST, 0, 0);
    chk(q, 8'hD0);
    $display("test commands done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    rst_n = 1;
    t_access();
    t_setup();
    t_prog();
    t_cmds();
    print_verdict();
  end
endmodule
`default_nettype wire
